// ===== kfarw_pkg.sv
/*
 * constants and carrier types for the keyboard controller side logic:
 * fast a20, alternate reset, irq latches, wake events, isolation.
 * assumes a single 100 MHz clock and a simple synchronous register port.
 */
package kfarw_pkg;

   // register locations
   localparam logic [7:0] SYS_CTRL_PORT_ADDR = 8'h92;
   localparam logic [7:0] KRA_CTRL_ADDR      = 8'hF0;
   localparam logic [7:0] GLOBAL_CFG_ADDR    = 8'h2C;
   localparam logic [7:0] WAKE_STAT_ADDR     = 8'hF1;
   localparam logic [7:0] WAKE_EN_ADDR       = 8'hF2;

   // reset values
   localparam logic [7:0] SYS_CTRL_RESET  = 8'h24;
   localparam logic [7:0] SYS_CTRL_FIXED1 = 8'h24;
   localparam logic [7:0] KRA_CTRL_RESET  = 8'h00;
   localparam logic [7:0] GLOBAL_CFG_RESET = 8'h00;

   // system control port fields
   localparam int SCP_ALT_RST_BIT = 0;
   localparam int SCP_FAST_A20_BIT = 1;

   // keyboard reset / a20 control fields
   localparam int KRA_PORT_EN_BIT   = 2;
   localparam int KRA_KBD_LATCH_BIT = 3;
   localparam int KRA_MOUSE_LATCH_BIT = 4;
   localparam int KRA_KBD_ISO_BIT   = 5;
   localparam int KRA_MOUSE_ISO_BIT = 6;

   // global configuration field
   localparam int GCFG_CORE_RESET_BIT = 6;

   // wake enable fields; status uses bits 3:0 in the same order
   localparam int WAKE_KBD_IRQ_BIT   = 0;
   localparam int WAKE_MOUSE_IRQ_BIT = 1;
   localparam int WAKE_KBD_DATA_BIT  = 2;
   localparam int WAKE_MOUSE_DATA_BIT = 3;
   localparam int WAKE_GLOBAL_EN_BIT = 7;

   // timing
   localparam int CLK_MHZ         = 100;
   localparam int RST_DELAY_US    = 14;
   localparam int RST_PULSE_US    = 6;
   localparam int RST_DELAY_CYC   = RST_DELAY_US * CLK_MHZ;
   localparam int RST_PULSE_CYC   = RST_PULSE_US * CLK_MHZ;

   typedef enum logic [1:0] {
      KFARW_IDLE  = 2'b00,
      KFARW_DELAY = 2'b01,
      KFARW_PULSE = 2'b11,
      KFARW_DONE  = 2'b10
   } kfarw_rst_e;

   // raw lines from keyboard and mouse
   typedef struct packed {
      logic kbd_clock_line;
      logic kbd_data_line;
      logic mouse_clock_line;
      logic mouse_data_line;
   } kfarw_lines_s;

endpackage : kfarw_pkg

// ===== kfarw_top.sv
/*
 * fast a20 gate, alternate cpu reset, keyboard/mouse irq latches,
 * wake event status and sleep isolation around a keyboard controller core.
 * assumes host register strobes are one-cycle and synchronous to REF_CLK,
 * and all pin inputs are synchronous to REF_CLK.
 */
// What this block does
// - a20 mask low only when both inputs low
// - writing port bit1 zero drives fast a20 low
// - writing port bit1 one forces mask high
// - reset drives fast a20 low
// - bit0 write: wait 14us, pulse 6us low
// - no new pulse until bit0 cleared
// - reset clears bit0, reset output high
// - port enable gates pulse; AND with core
// - combined pulse on pin, polarity selectable
// - mouse irq raw-and-latched or latched only
// - keyboard irq raw-and-latched or latched only
// - four separate wake status bits
// - wake output needs own and global enable
// - irq wakes only under main power
// - mouse isolation blocks lines to core
// - keyboard isolation blocks lines to core
// - core reset bit held until host clears
// - port at 92h, reset 24h, fixed bits
`timescale 1ns/1ps
module kfarw_top #(
   parameter int RST_DELAY_CYCLES = kfarw_pkg::RST_DELAY_CYC,
   parameter int RST_PULSE_CYCLES = kfarw_pkg::RST_PULSE_CYC
) (
   input  wire logic                 REF_CLK,
   input  wire logic                 RST,
   // host register port
   input  wire logic                 REG_WR,
   input  wire logic                 REG_RD,
   input  wire logic [7:0]           REG_ADDR,
   input  wire logic [7:0]           REG_WDATA,
   output logic      [7:0]           REG_RDATA,
   // keyboard controller core side
   input  wire logic                 KBC_A20_OUTPUT,
   input  wire logic                 KBC_RESET_OUTPUT_N,
   input  wire logic                 KBC_KBD_IRQ,
   input  wire logic                 KBC_MOUSE_IRQ,
   input  wire logic                 CPU_RESET_INPUT,
   input  wire logic                 KEYBOARD_RESET_POLARITY,
   input  wire logic                 MAIN_POWER_OK,
   input  wire kfarw_pkg::kfarw_lines_s LINES_IN,
   output kfarw_pkg::kfarw_lines_s   CORE_LINES,
   output logic                      KBD_IRQ,
   output logic                      MOUSE_IRQ,
   output logic                      KBC_CORE_RESET,
   // cpu and system side
   output logic                      CPU_A20_MASK_N,
   output logic                      FAST_A20_SIGNAL,
   output logic                      ALTERNATE_CPU_RESET_N,
   output logic                      KEYBOARD_RESET_PIN,
   output logic                      WAKE_EVENT
);

   localparam int CW = $clog2(RST_DELAY_CYCLES + RST_PULSE_CYCLES + 1);

   // elaboration check: a zero count would wrap cnt_q to its largest value, not skip
   if (RST_DELAY_CYCLES < 1 || RST_PULSE_CYCLES < 1) begin : g_bad_counts
      $error("reset delay and pulse counts must be at least one");
   end

   logic [7:0]            scp_q;
   logic [7:0]            kra_q;
   logic [7:0]            gcfg_q;
   logic [3:0]            wake_stat_q;
   logic [7:0]            wake_en_q;
   kfarw_pkg::kfarw_rst_e rst_st_q;
   logic [CW-1:0]         cnt_q;
   logic                  kirq_latch_q;
   logic                  mirq_latch_q;
   logic                  kbd_data_line_prev_q;
   logic                  mouse_data_line_prev_q;
   logic                  kirq_prev_q;
   logic                  mirq_prev_q;

   // decode shared by every register write
   function automatic logic hit(input logic [7:0] a, input logic [7:0] loc);
      hit = (a == loc);
   endfunction : hit

   logic wr_scp;
   logic wr_kra;
   logic wr_gcfg;
   logic wr_wstat;
   logic wr_wen;
   logic port_en;

   // the port is only reachable while enabled by the control register
   assign port_en  = kra_q[kfarw_pkg::KRA_PORT_EN_BIT];
   assign wr_scp   = REG_WR && port_en
                     && hit(REG_ADDR, kfarw_pkg::SYS_CTRL_PORT_ADDR);
   assign wr_kra   = REG_WR && hit(REG_ADDR, kfarw_pkg::KRA_CTRL_ADDR);
   assign wr_gcfg  = REG_WR && hit(REG_ADDR, kfarw_pkg::GLOBAL_CFG_ADDR);
   assign wr_wstat = REG_WR && hit(REG_ADDR, kfarw_pkg::WAKE_STAT_ADDR);
   assign wr_wen   = REG_WR && hit(REG_ADDR, kfarw_pkg::WAKE_EN_ADDR);

   // system control port; only bits 1:0 are storage, rest fixed
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         scp_q <= kfarw_pkg::SYS_CTRL_RESET;
      end else if (wr_scp) begin
         scp_q <= (REG_WDATA & 8'h03) | kfarw_pkg::SYS_CTRL_FIXED1;
      end
   end

   // keyboard reset / a20 control register
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         kra_q <= kfarw_pkg::KRA_CTRL_RESET;
      end else if (wr_kra) begin
         kra_q <= REG_WDATA;
      end
   end

   // core reset bit is plain storage, never self-clearing
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         gcfg_q <= kfarw_pkg::GLOBAL_CFG_RESET;
      end else if (wr_gcfg) begin
         gcfg_q <= REG_WDATA;
      end
   end

   // wake enables: bits 3:0 one per event, bit 7 the global enable
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wake_en_q <= 8'h00;
      end else if (wr_wen) begin
         wake_en_q <= REG_WDATA;
      end
   end

   // alternate reset sequencer: delay then low pulse, one per bit0 set
   // the delay runs two cycles past its count; the rule is a minimum
   logic bit0_q;
   assign bit0_q = scp_q[kfarw_pkg::SCP_ALT_RST_BIT];
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rst_st_q <= kfarw_pkg::KFARW_IDLE;
         cnt_q    <= '0;
      end else begin
         unique case (rst_st_q)
            kfarw_pkg::KFARW_IDLE: begin
               if (bit0_q && port_en) begin
                  rst_st_q <= kfarw_pkg::KFARW_DELAY;
                  cnt_q    <= CW'(RST_DELAY_CYCLES - 1);
               end
            end
            kfarw_pkg::KFARW_DELAY: begin
               if (cnt_q == '0) begin
                  rst_st_q <= kfarw_pkg::KFARW_PULSE;
                  cnt_q    <= CW'(RST_PULSE_CYCLES - 1);
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            kfarw_pkg::KFARW_PULSE: begin
               if (cnt_q == '0) begin
                  rst_st_q <= kfarw_pkg::KFARW_DONE;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            kfarw_pkg::KFARW_DONE: begin
               // rearm only after bit0 has gone back to zero
               if (!bit0_q) begin
                  rst_st_q <= kfarw_pkg::KFARW_IDLE;
               end
            end
         endcase
      end
   end

   // reset outputs registered; pulse low while in the pulse state
   logic alt_rst_n_d;
   assign alt_rst_n_d = (rst_st_q != kfarw_pkg::KFARW_PULSE);
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ALTERNATE_CPU_RESET_N <= 1'b1;
         KEYBOARD_RESET_PIN    <= 1'b1;
      end else begin
         ALTERNATE_CPU_RESET_N <= alt_rst_n_d;
         // combined active-low pulse, polarity inverted when asked
         KEYBOARD_RESET_PIN <= (alt_rst_n_d & KBC_RESET_OUTPUT_N)
                               ^ KEYBOARD_RESET_POLARITY;
      end
   end

   // a20: fast signal straight from bit1; mask is the or of sources
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         FAST_A20_SIGNAL <= 1'b0;
         CPU_A20_MASK_N  <= 1'b0;
      end else begin
         FAST_A20_SIGNAL <= scp_q[kfarw_pkg::SCP_FAST_A20_BIT];
         CPU_A20_MASK_N  <= KBC_A20_OUTPUT
                            | scp_q[kfarw_pkg::SCP_FAST_A20_BIT]
                            | CPU_RESET_INPUT;
      end
   end

   // irq latches: set on a rising irq, cleared when the raw irq drops
   // so a read of the core data that drops the irq also ends the latch
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         kirq_latch_q <= 1'b0;
         mirq_latch_q <= 1'b0;
         kirq_prev_q  <= 1'b0;
         mirq_prev_q  <= 1'b0;
      end else begin
         kirq_prev_q <= KBC_KBD_IRQ;
         mirq_prev_q <= KBC_MOUSE_IRQ;
         if (KBC_KBD_IRQ && !kirq_prev_q)
            kirq_latch_q <= 1'b1;
         else if (!KBC_KBD_IRQ)
            kirq_latch_q <= 1'b0;
         if (KBC_MOUSE_IRQ && !mirq_prev_q)
            mirq_latch_q <= 1'b1;
         else if (!KBC_MOUSE_IRQ)
            mirq_latch_q <= 1'b0;
      end
   end

   // raw-and-latched drops with the core; latched alone lasts a cycle more
   logic kirq_sel;
   logic mirq_sel;
   assign kirq_sel = kra_q[kfarw_pkg::KRA_KBD_LATCH_BIT]
                     ? kirq_latch_q
                     : (KBC_KBD_IRQ & kirq_latch_q);
   assign mirq_sel = kra_q[kfarw_pkg::KRA_MOUSE_LATCH_BIT]
                     ? mirq_latch_q
                     : (KBC_MOUSE_IRQ & mirq_latch_q);

   // filtered irqs leave through a flop so the pins never glitch
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         KBD_IRQ   <= 1'b0;
         MOUSE_IRQ <= 1'b0;
      end else begin
         KBD_IRQ   <= kirq_sel;
         MOUSE_IRQ <= mirq_sel;
      end
   end

   // isolation: blocked lines idle high to the core, which is the bus idle
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         CORE_LINES <= '1;
      end else begin
         CORE_LINES.kbd_clock_line <= LINES_IN.kbd_clock_line
                                      | kra_q[kfarw_pkg::KRA_KBD_ISO_BIT];
         CORE_LINES.kbd_data_line  <= LINES_IN.kbd_data_line
                                      | kra_q[kfarw_pkg::KRA_KBD_ISO_BIT];
         CORE_LINES.mouse_clock_line <= LINES_IN.mouse_clock_line
                                      | kra_q[kfarw_pkg::KRA_MOUSE_ISO_BIT];
         CORE_LINES.mouse_data_line  <= LINES_IN.mouse_data_line
                                      | kra_q[kfarw_pkg::KRA_MOUSE_ISO_BIT];
      end
   end

   // core held in reset for as long as the host leaves the bit set
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         KBC_CORE_RESET <= 1'b0;
      end else begin
         KBC_CORE_RESET <= gcfg_q[kfarw_pkg::GCFG_CORE_RESET_BIT];
      end
   end

   // wake events; data edges see raw lines, ahead of the isolation gate
   logic [3:0] wake_evt;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         kbd_data_line_prev_q <= 1'b1;
         mouse_data_line_prev_q <= 1'b1;
      end else begin
         kbd_data_line_prev_q <= LINES_IN.kbd_data_line;
         mouse_data_line_prev_q <= LINES_IN.mouse_data_line;
      end
   end

   // irq wakes need main power; data edges run on standby too
   always_comb begin
      wake_evt = 4'h0;
      wake_evt[kfarw_pkg::WAKE_KBD_IRQ_BIT]   = kirq_sel && MAIN_POWER_OK;
      wake_evt[kfarw_pkg::WAKE_MOUSE_IRQ_BIT] = mirq_sel && MAIN_POWER_OK;
      // falling edge is the active edge: start bit of a frame
      wake_evt[kfarw_pkg::WAKE_KBD_DATA_BIT]  =
         kbd_data_line_prev_q && !LINES_IN.kbd_data_line;
      wake_evt[kfarw_pkg::WAKE_MOUSE_DATA_BIT] =
         mouse_data_line_prev_q && !LINES_IN.mouse_data_line;
   end

   // sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wake_stat_q <= 4'h0;
      end else begin
         wake_stat_q <= (wake_stat_q & ~(wr_wstat ? REG_WDATA[3:0] : 4'h0))
                        | wake_evt;
      end
   end

   // event output is a level that stays up until the status or its enables are cleared
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         WAKE_EVENT <= 1'b0;
      end else begin
         WAKE_EVENT <= |(wake_stat_q & wake_en_q[3:0])
                       && wake_en_q[kfarw_pkg::WAKE_GLOBAL_EN_BIT];
      end
   end

   // read data registered one cycle after the read strobe
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         if (hit(REG_ADDR, kfarw_pkg::SYS_CTRL_PORT_ADDR) && port_en)
            REG_RDATA <= scp_q;
         else if (hit(REG_ADDR, kfarw_pkg::KRA_CTRL_ADDR))
            REG_RDATA <= kra_q;
         else if (hit(REG_ADDR, kfarw_pkg::GLOBAL_CFG_ADDR))
            REG_RDATA <= gcfg_q;
         else if (hit(REG_ADDR, kfarw_pkg::WAKE_STAT_ADDR))
            REG_RDATA <= {4'h0, wake_stat_q};
         else if (hit(REG_ADDR, kfarw_pkg::WAKE_EN_ADDR))
            REG_RDATA <= wake_en_q;
         else
            REG_RDATA <= 8'hFF; // unmapped or disabled port
      end
   end

endmodule : kfarw_top

// ===== kfarw_monitor.sv
/* checker for kfarw_top: a20 mask, reset pulse timing, irq filters,
   reset pin and core reset, seen at the top ports only.
   assumes one clock domain; bound into kfarw_top below. */
`timescale 1ns/1ps
module kfarw_monitor #(
   parameter int RST_DELAY_CYCLES = 4,
   parameter int RST_PULSE_CYCLES = 3
) (
   input wire logic       REF_CLK,
   input wire logic       RST,
   input wire logic       REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       KBC_A20_OUTPUT,
   input wire logic       KBC_RESET_OUTPUT_N,
   input wire logic       KBC_KBD_IRQ,
   input wire logic       KBC_MOUSE_IRQ,
   input wire logic       CPU_RESET_INPUT,
   input wire logic       KEYBOARD_RESET_POLARITY,
   input wire logic       KBD_IRQ,
   input wire logic       MOUSE_IRQ,
   input wire logic       KBC_CORE_RESET,
   input wire logic       CPU_A20_MASK_N,
   input wire logic       FAST_A20_SIGNAL,
   input wire logic       ALTERNATE_CPU_RESET_N,
   input wire logic       KEYBOARD_RESET_PIN
);
   logic [15:0] low_cnt;
   logic [15:0] wr_cnt;

   // low-phase length and time since a port write; wr_cnt saturates
   // so a long idle spell cannot wrap into a falsely short delay
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         low_cnt <= 16'h0000;
         wr_cnt  <= 16'hFFFF;
      end else begin
         low_cnt <= ALTERNATE_CPU_RESET_N ? 16'h0000 : low_cnt + 16'h0001;
         if (REG_WR && REG_ADDR == kfarw_pkg::SYS_CTRL_PORT_ADDR)
            wr_cnt <= 16'h0000;
         else if (wr_cnt != 16'hFFFF) wr_cnt <= wr_cnt + 16'h0001;
      end
   end

   default clocking mon_cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   // core reset write followed by a quiet cycle
   sequence core_wr_s(logic v);
      REG_WR && REG_ADDR == kfarw_pkg::GLOBAL_CFG_ADDR
      && REG_WDATA[kfarw_pkg::GCFG_CORE_RESET_BIT] == v ##1 !REG_WR;
   endsequence

   a20_high_a: assert property (
      (KBC_A20_OUTPUT || CPU_RESET_INPUT) |=> CPU_A20_MASK_N)
      else $error("a20 mask low with a high input");
   mask_low_a: assert property (
      !KBC_A20_OUTPUT && !CPU_RESET_INPUT
      |=> CPU_A20_MASK_N == FAST_A20_SIGNAL)
      else $error("a20 mask differs from fast a20 with core inputs low");
   fast_mask_a: assert property (
      FAST_A20_SIGNAL |-> CPU_A20_MASK_N)
      else $error("fast a20 did not force the mask high");
   pulse_width_a: assert property (
      $rose(ALTERNATE_CPU_RESET_N) |-> low_cnt == RST_PULSE_CYCLES)
      else $error("alternate reset pulse width wrong");
   pulse_delay_a: assert property (
      $fell(ALTERNATE_CPU_RESET_N) |-> wr_cnt >= RST_DELAY_CYCLES)
      else $error("alternate reset pulse came too early");
   kirq_low_a: assert property (
      !KBC_KBD_IRQ [*2] |=> !KBD_IRQ) else $error("keyboard irq stuck");
   mirq_low_a: assert property (
      !KBC_MOUSE_IRQ [*2] |=> !MOUSE_IRQ) else $error("mouse irq stuck");
   krst_pin_a: assert property (
      !KBC_RESET_OUTPUT_N && !KEYBOARD_RESET_POLARITY
      |=> !KEYBOARD_RESET_PIN) else $error("reset pin not low");
   krst_inv_a: assert property (
      !KBC_RESET_OUTPUT_N && KEYBOARD_RESET_POLARITY
      |=> KEYBOARD_RESET_PIN) else $error("inverted reset pin not high");
   core_set_a: assert property (
      core_wr_s(1'b1) |=> KBC_CORE_RESET) else $error("core not held");
   core_clr_a: assert property (
      core_wr_s(1'b0) |=> !KBC_CORE_RESET) else $error("core not freed");
endmodule : kfarw_monitor

bind kfarw_top kfarw_monitor #(
   .RST_DELAY_CYCLES(RST_DELAY_CYCLES),
   .RST_PULSE_CYCLES(RST_PULSE_CYCLES)
) mon (
   .REF_CLK(REF_CLK), .RST(RST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .KBC_A20_OUTPUT(KBC_A20_OUTPUT),
   .KBC_RESET_OUTPUT_N(KBC_RESET_OUTPUT_N), .KBC_KBD_IRQ(KBC_KBD_IRQ),
   .KBC_MOUSE_IRQ(KBC_MOUSE_IRQ), .CPU_RESET_INPUT(CPU_RESET_INPUT),
   .KEYBOARD_RESET_POLARITY(KEYBOARD_RESET_POLARITY), .KBD_IRQ(KBD_IRQ),
   .MOUSE_IRQ(MOUSE_IRQ), .KBC_CORE_RESET(KBC_CORE_RESET),
   .CPU_A20_MASK_N(CPU_A20_MASK_N), .FAST_A20_SIGNAL(FAST_A20_SIGNAL),
   .ALTERNATE_CPU_RESET_N(ALTERNATE_CPU_RESET_N),
   .KEYBOARD_RESET_PIN(KEYBOARD_RESET_PIN)
);

// ===== kfarw_line_model.sv
/* keyboard and mouse line model with pull-ups on all four lines.
   assumes the bench changes its requests just after a clock edge. */
`timescale 1ns/1ps
module kfarw_line_model (
   input  wire logic [1:0]         low_req,
   input  wire logic               pat_en,
   input  wire logic [3:0]         pat,
   output kfarw_pkg::kfarw_lines_s lines
);
   // released lines sit high; a request pulls a data line low, which
   // gives the wake logic its falling edge
   assign lines = pat_en ? pat : {1'b1, ~low_req[0], 1'b1, ~low_req[1]};
endmodule : kfarw_line_model

// ===== test_kfarw_top.sv
/* self-checking bench for kfarw_top with the line model beside it.
   assumes short delay and pulse counts so the run stays brief. */
`timescale 1ns/1ps
module test_kfarw_top;
   localparam int DLY = 4;
   localparam int PLS = 3;
   logic        ck = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        a20 = 1'b0, cpur = 1'b0, kbcn = 1'b1, pol = 1'b0;
   logic        kirq = 1'b0, mirq = 1'b0, pwr = 1'b1, pen = 1'b0;
   logic        kout, mout, crst, mask, fast, altn, pin, wake;
   logic [1:0]  lreq = 2'b00;
   logic [3:0]  pat = 4'hF;
   logic [7:0]  adr = 8'h00, wd = 8'h00, rdat;
   logic [31:0] seed = 32'h3327CD8D;
   int          err_total = 0, cmp_count = 0;
   kfarw_pkg::kfarw_lines_s lines, core;

   always #5 ck = ~ck;

   kfarw_line_model lm (.low_req(lreq), .pat_en(pen), .pat(pat),
      .lines(lines));
   kfarw_top #(.RST_DELAY_CYCLES(DLY), .RST_PULSE_CYCLES(PLS)) dut (
      .REF_CLK(ck), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(adr),
      .REG_WDATA(wd), .REG_RDATA(rdat), .KBC_A20_OUTPUT(a20),
      .KBC_RESET_OUTPUT_N(kbcn), .KBC_KBD_IRQ(kirq), .KBC_MOUSE_IRQ(mirq),
      .CPU_RESET_INPUT(cpur), .KEYBOARD_RESET_POLARITY(pol),
      .MAIN_POWER_OK(pwr), .LINES_IN(lines), .CORE_LINES(core),
      .KBD_IRQ(kout), .MOUSE_IRQ(mout), .KBC_CORE_RESET(crst),
      .CPU_A20_MASK_N(mask), .FAST_A20_SIGNAL(fast),
      .ALTERNATE_CPU_RESET_N(altn), .KEYBOARD_RESET_PIN(pin),
      .WAKE_EVENT(wake));

   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function logic exp_pin(input logic a, k, p);
      return (a & k) ^ p;
   endfunction : exp_pin
   // isolated lines reach the core as released (high)
   function logic [3:0] exp_core(input logic [3:0] p, input logic mi, ki);
      return {ki ? 2'b11 : p[3:2], mi ? 2'b11 : p[1:0]};
   endfunction : exp_core

   task finish_test;
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [7:0] g, e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge ck);
   endtask : cyc
   task do_reset;
      rst <= 1'b1;
      cyc(3);
      rst <= 1'b0;
      cyc(1);
   endtask : do_reset
   task wrt(input logic [7:0] a, d);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge ck);
      wr <= 1'b0;
      // an idle edge, so back-to-back writes never assign wr twice at once
      @(posedge ck);
   endtask : wrt
   task rdc(input logic [7:0] a, e);
      adr <= a;
      rd <= 1'b1;
      @(posedge ck);
      rd <= 1'b0;
      @(posedge ck);
      chk(rdat, e);
   endtask : rdc
   // times the fall and the low phase at falling edges, off the launch edge
   task pulse(input logic e);
      int n, w;
      n = 0;
      w = 0;
      while (altn === 1'b1 && n < 40) begin
         @(negedge ck);
         n++;
      end
      while (altn === 1'b0 && w < 40) begin
         @(negedge ck);
         w++;
         if (w == 2) chk({7'h0, pin}, {7'h0, exp_pin(1'b0, kbcn, pol)});
      end
      @(posedge ck);
      chk(8'(w), e ? 8'(PLS) : 8'h00);
      if (e) chk({7'h0, n >= DLY}, 8'h01);
   endtask : pulse

   // watchdog: the sequence needs a few hundred cycles at most
   initial begin
      cyc(8000);
      err_total++;
      finish_test;
   end

   initial begin
      do_reset;
      chk({altn, fast, crst, wake, core}, 8'h8F);
      rdc(8'hF0, 8'h00);
      rdc(8'h92, 8'hFF);
      wrt(8'hF0, 8'h04);
      rdc(8'h92, 8'h24);
      for (int i = 0; i < 8; i++) begin
         wrt(8'h92, {6'h0, i[0], 1'b0});
         a20 <= i[1];
         cpur <= i[2];
         cyc(3);
         chk({6'h0, fast, mask}, {6'h0, i[0], i[0] | i[1] | i[2]});
         rdc(8'h92, {6'b001001, i[0], 1'b0});
      end
      a20 <= 1'b0;
      cpur <= 1'b0;
      wrt(8'h92, 8'h01);
      pulse(1'b1);
      pulse(1'b0);
      wrt(8'h92, 8'h00);
      wrt(8'h92, 8'h01);
      pulse(1'b1);
      do_reset;
      wrt(8'hF0, 8'h04);
      rdc(8'h92, 8'h24);
      wrt(8'hF0, 8'h00);
      wrt(8'h92, 8'h01);
      pulse(1'b0);
      pol <= 1'b1;
      kbcn <= 1'b0;
      cyc(3);
      chk({7'h0, pin}, {7'h0, exp_pin(1'b1, 1'b0, 1'b1)});
      pol <= 1'b0;
      cyc(3);
      chk({7'h0, pin}, {7'h0, exp_pin(1'b1, 1'b0, 1'b0)});
      kbcn <= 1'b1;
      wrt(8'hF2, 8'h8F);
      for (int m = 0; m < 2; m++) begin
         wrt(8'hF0, {3'h0, m[0], m[0], 3'h0});
         wrt(8'hF1, 8'h0F);
         kirq <= 1'b1;
         mirq <= 1'b1;
         cyc(3);
         chk({6'h0, kout, mout}, 8'h03);
         kirq <= 1'b0;
         mirq <= 1'b0;
         // latched-only mode outlasts the raw irq by one cycle
         cyc(2);
         chk({6'h0, kout, mout}, {6'h0, m[0], m[0]});
         cyc(1);
         chk({6'h0, kout, mout}, 8'h00);
         rdc(8'hF1, 8'h03);
         chk({7'h0, wake}, 8'h01);
      end
      wrt(8'hF2, 8'h8C);
      cyc(2);
      chk({7'h0, wake}, 8'h00);
      wrt(8'hF2, 8'h0F);
      cyc(2);
      chk({7'h0, wake}, 8'h00);
      // standby power with both sides isolated
      pwr <= 1'b0;
      wrt(8'hF0, 8'h60);
      wrt(8'hF1, 8'h0F);
      kirq <= 1'b1;
      mirq <= 1'b1;
      lreq <= 2'b11;
      cyc(3);
      kirq <= 1'b0;
      mirq <= 1'b0;
      lreq <= 2'b00;
      cyc(3);
      rdc(8'hF1, 8'h0C);
      pwr <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         pen <= 1'b1;
         pat <= seed[3:0];
         wrt(8'hF0, {1'b0, seed[5], seed[4], 5'h0});
         cyc(3);
         chk({4'h0, core}, {4'h0, exp_core(seed[3:0], seed[5], seed[4])});
      end
      pen <= 1'b0;
      wrt(8'h2C, 8'h40);
      cyc(4);
      chk({7'h0, crst}, 8'h01);
      rdc(8'h2C, 8'h40);
      wrt(8'h2C, 8'h00);
      cyc(2);
      chk({7'h0, crst}, 8'h00);
      finish_test;
   end
endmodule : test_kfarw_top
